// file: bench/peq_qualifier_chk.sv
`timescale 1ns/1ps
module peq_qualifier_chk (
    input wire [7:0] evsel_code_i,
    input wire [7:0] evsel_umask_i,
    input wire       mclk_i,
    input wire       rstn_i,
    input wire       sel_counter_one_i,
    input wire       div_exec_i,
    input wire       div_busy_i,
    input wire       inc_counter_zero_o,
    input wire       inc_counter_one_o,
    input wire       event_valid_o
);
    wire [7:0] c = evsel_code_i;
    wire       z = evsel_umask_i == 8'h00;
    wire       o = sel_counter_one_i;
    wire       q0 = inc_counter_zero_o, q1 = inc_counter_one_o, v = event_valid_o;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    div_cnt_a: assert property (c==8'h13 && z && o && div_exec_i |=> q1) else $error("div");
    div_idle_a: assert property (c==8'h13 && o && !div_exec_i |=> !q1) else $error("idle");
    div_ctr_a: assert property (c==8'h13 && !o |=> !q0 && !v) else $error("ctr");
    busy_cnt_a: assert property (c==8'h14 && z && !o && div_busy_i |=> q0) else $error("busy");
    zero_only_a: assert property ((c==8'h14 || c==8'h18) && o |=> !q1 && !v) else $error("c0");
    fwd_ctr_a: assert property (c==8'h19 && !o |=> !q0 && !v) else $error("fwd");
    l2_valid_a: assert property ((c==8'h21 || c==8'h23) |=> v) else $error("l2");
    no_event_a: assert property (c==8'h00 |=> !q0 && !q1 && !v) else $error("none");
    div_mask_a: assert property (c==8'h13 && !z |=> !q0 && !q1 && !v) else $error("dmask");
    fwd_mask_a: assert property (c==8'h19 && evsel_umask_i > 8'h02 |=> !q0 && !q1 && !v)
        else $error("fmask");
    cover property (q0);
    cover property (q1);
    cover property (c==8'h19 && q1);
endmodule
bind peq_qualifier peq_qualifier_chk chk_u (
    .evsel_code_i       (evsel_code_i),
    .evsel_umask_i      (evsel_umask_i),
    .mclk_i             (mclk_i),
    .rstn_i             (rstn_i),
    .sel_counter_one_i  (sel_counter_one_i),
    .div_exec_i         (div_exec_i),
    .div_busy_i         (div_busy_i),
    .inc_counter_zero_o (inc_counter_zero_o),
    .inc_counter_one_o  (inc_counter_one_o),
    .event_valid_o      (event_valid_o)
);

// file: bench/peq_qualifier_tb.sv
`timescale 1ns/1ps
module peq_qualifier_tb;
    reg  [7:0]  evsel_code_i, evsel_umask_i;
    reg  [11:0] s;
    reg         mclk_i, rstn_i, sel_counter_one_i;
    wire        inc_counter_zero_o, inc_counter_one_o, event_valid_o;
    wire [2:0]  r = {inc_counter_zero_o, inc_counter_one_o, event_valid_o};
    integer     error_cnt = 0, n_checks = 0;
    peq_qualifier dut_u (
        .mclk_i                (mclk_i),
        .rstn_i                (rstn_i),
        .evsel_code_i          (evsel_code_i),
        .evsel_umask_i         (evsel_umask_i),
        .sel_counter_one_i     (sel_counter_one_i),
        .div_exec_i            (s[11]),
        .div_busy_i            (s[10]),
        .other_unit_busy_i     (s[9]),
        .load_busy_i           (s[8]),
        .uop_after_div_start_i (s[7]),
        .float_bypass_i        (s[6]),
        .vector_bypass_i       (s[5]),
        .load_bypass_penalty_i (s[4]),
        .l2_addr_this_i        (s[3]),
        .l2_addr_other_i       (s[2]),
        .l2_rdata_this_i       (s[1]),
        .l2_rdata_other_i      (s[0]),
        .inc_counter_zero_o    (inc_counter_zero_o),
        .inc_counter_one_o     (inc_counter_one_o),
        .event_valid_o         (event_valid_o)
    );
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (100) @(posedge mclk_i);
        error_cnt++;
        test_done;
    end
    // Packed step: code, mask, inputs, counter select, then expected {zero, one, valid}
    task t(input [31:0] p);
        @(posedge mclk_i);
        {evsel_code_i, evsel_umask_i, s, sel_counter_one_i} <= p[31:3];
        @(posedge mclk_i);
        #1;
        n_checks++;
        if (r !== p[2:0]) begin
            error_cnt++;
            $display("Error %0t exp %h got %h", $time, p[2:0], r);
        end
    endtask
    task core_t;
        t(32'h1300800b);
        t(32'h13000009);
        t(32'h13008000);
        t(32'h14004005);
        t(32'h14004008);
        t(32'h18004805);
        t(32'h18007801);
        t(32'h18007005);
        t(32'h1200fff8);
        t(32'h13c08008);
        $display("core events done");
    endtask
    task bus_t;
        t(32'h1900040b);
        t(32'h19000400);
        t(32'h1901020b);
        t(32'h19010409);
        t(32'h1902010b);
        t(32'h19020409);
        t(32'h19030708);
        t(32'h21000085);
        t(32'h21000041);
        t(32'h21c0004b);
        t(32'h23c00015);
        t(32'h23400025);
        t(32'h23000019);
        $display("bus events done");
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        rstn_i <= 1'b0;
        {evsel_code_i, evsel_umask_i, s, sel_counter_one_i} <= 29'h0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        core_t;
        bus_t;
        test_done;
    end
endmodule

// file: logic/peq_qualifier.v
`timescale 1ns/1ps
`include "peq_regs.vh"
module peq_qualifier (
    input  wire       mclk_i,
    input  wire       rstn_i,
    input  wire [7:0] evsel_code_i,
    input  wire [7:0] evsel_umask_i,
    input  wire       sel_counter_one_i,
    input  wire       div_exec_i,
    input  wire       div_busy_i,
    input  wire       other_unit_busy_i,
    input  wire       load_busy_i,
    input  wire       uop_after_div_start_i,
    input  wire       float_bypass_i,
    input  wire       vector_bypass_i,
    input  wire       load_bypass_penalty_i,
    input  wire       l2_addr_this_i,
    input  wire       l2_addr_other_i,
    input  wire       l2_rdata_this_i,
    input  wire       l2_rdata_other_i,
    output reg        inc_counter_zero_o,
    output reg        inc_counter_one_o,
    output reg        event_valid_o
);
    // Decoded selections, one per listed event
    wire       div_sel;
    wire       div_busy_sel;
    wire       div_only_sel;
    wire       float_sel;
    wire       vector_sel;
    wire       load_sel;
    wire       l2_addr_sel;
    wire       l2_rdata_sel;
    wire       l2_addr_hit;
    wire       l2_rdata_hit;
    reg        other_busy;
    reg        div_only_cond;
    reg        one_allowed;
    reg        zero_allowed;
    reg        hit_d;
    reg        cond_d;
    reg        inc_zero_d;
    reg        inc_one_d;
    reg        valid_d;

    peq_event_match #(
        .CODE  (`PEQ_EV_DIV),
        .UMASK (`PEQ_UM_NONE),
        .EXACT (1'b1)
    ) div_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (div_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_DIV_BUSY),
        .UMASK (`PEQ_UM_NONE),
        .EXACT (1'b1)
    ) div_busy_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (div_busy_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_DIV_ONLY),
        .UMASK (`PEQ_UM_NONE),
        .EXACT (1'b1)
    ) div_only_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (div_only_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_BYPASS),
        .UMASK (`PEQ_UM_FLOAT),
        .EXACT (1'b1)
    ) float_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (float_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_BYPASS),
        .UMASK (`PEQ_UM_VECTOR),
        .EXACT (1'b1)
    ) vector_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (vector_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_BYPASS),
        .UMASK (`PEQ_UM_LOAD),
        .EXACT (1'b1)
    ) load_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (load_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_L2_ADDR),
        .UMASK (`PEQ_UM_NONE),
        .EXACT (1'b0)
    ) l2_addr_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (l2_addr_sel)
    );

    peq_event_match #(
        .CODE  (`PEQ_EV_L2_RDATA),
        .UMASK (`PEQ_UM_NONE),
        .EXACT (1'b0)
    ) l2_rdata_match_u (
        .code_i  (evsel_code_i),
        .umask_i (evsel_umask_i),
        .match_o (l2_rdata_sel)
    );

    peq_core_merge #(
        .BOTH_SEL (`PEQ_UM_CORE_BOTH)
    ) l2_addr_merge_u (
        .core_sel_i (evsel_umask_i[`PEQ_UM_CORE_LSB +: 2]),
        .this_i     (l2_addr_this_i),
        .other_i    (l2_addr_other_i),
        .hit_o      (l2_addr_hit)
    );

    peq_core_merge #(
        .BOTH_SEL (`PEQ_UM_CORE_BOTH)
    ) l2_rdata_merge_u (
        .core_sel_i (evsel_umask_i[`PEQ_UM_CORE_LSB +: 2]),
        .this_i     (l2_rdata_this_i),
        .other_i    (l2_rdata_other_i),
        .hit_o      (l2_rdata_hit)
    );

    always @* begin
        // Only later uops disturb the divider-only state; loads count as hitting
        other_busy    = uop_after_div_start_i & (other_unit_busy_i | load_busy_i);
        div_only_cond = div_busy_i & ~other_busy;
        hit_d         = div_sel
                      | div_busy_sel
                      | div_only_sel
                      | float_sel
                      | vector_sel
                      | load_sel
                      | l2_addr_sel
                      | l2_rdata_sel;
        // Bus events may use either counter
        one_allowed   = div_sel
                      | float_sel
                      | vector_sel
                      | load_sel
                      | l2_addr_sel
                      | l2_rdata_sel;
        zero_allowed  = div_busy_sel
                      | div_only_sel
                      | l2_addr_sel
                      | l2_rdata_sel;
        cond_d        = (div_sel & div_exec_i)
                      | (div_busy_sel & div_busy_i)
                      | (div_only_sel & div_only_cond)
                      | (float_sel & float_bypass_i)
                      | (vector_sel & vector_bypass_i)
                      | (load_sel & load_bypass_penalty_i)
                      | (l2_addr_sel & l2_addr_hit)
                      | (l2_rdata_sel & l2_rdata_hit);
        // One increment per qualifying cycle, only on a permitted counter
        inc_zero_d    = hit_d & cond_d & zero_allowed & ~sel_counter_one_i;
        inc_one_d     = hit_d & cond_d & one_allowed & sel_counter_one_i;
        valid_d       = hit_d & (sel_counter_one_i ? one_allowed : zero_allowed);
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            inc_counter_zero_o <= 1'b0;
            inc_counter_one_o  <= 1'b0;
            event_valid_o      <= 1'b0;
        end else begin
            inc_counter_zero_o <= inc_zero_d;
            inc_counter_one_o  <= inc_one_d;
            event_valid_o      <= valid_d;
        end
    end
endmodule

// Matches one listed event; bus events leave the mask to the core merge
module peq_event_match #(
    parameter [7:0] CODE  = 8'h00,
    parameter [7:0] UMASK = 8'h00,
    parameter [0:0] EXACT = 1'b1
) (
    input  wire [7:0] code_i,
    input  wire [7:0] umask_i,
    output wire       match_o
);
    wire code_eq;
    wire umask_eq;

    assign code_eq  = (code_i == CODE);
    assign umask_eq = EXACT ? (umask_i == UMASK) : 1'b1;
    assign match_o  = code_eq & umask_eq;
endmodule

// Folds the other core's bus use in only when both cores are selected
module peq_core_merge #(
    parameter [1:0] BOTH_SEL = `PEQ_UM_CORE_BOTH
) (
    input  wire [1:0] core_sel_i,
    input  wire       this_i,
    input  wire       other_i,
    output wire       hit_o
);
    wire both_cores;

    assign both_cores = (core_sel_i == BOTH_SEL);
    assign hit_o      = this_i | (both_cores & other_i);
endmodule

// file: logic/peq_regs.vh
// Contract
// - Event 13H/00H counts each divide or square root, counter one only
// - Event 14H/00H counts divider busy cycles, counter zero only
// - Event 18H/00H counts divider-only busy cycles, counter zero only
// - Divider-only check sees uops dispatched after divide start; loads assumed hitting
// - Event 19H/00H counts float ops using non-float data, counter one only
// - Event 19H/01H counts vector ops using non-vector data, counter one only
// - Event 19H/02H counts load bypass penalty cycles, counter one only
// - Event 21H counts cycles second-level address bus carries an access
// - Event 23H counts cycles second-level data bus returns data to core
// - Core-select mask bits choose this core alone or both cores
`ifndef PEQ_REGS_VH
`define PEQ_REGS_VH
`define PEQ_EV_DIV          8'h13
`define PEQ_EV_DIV_BUSY     8'h14
`define PEQ_EV_DIV_ONLY     8'h18
`define PEQ_EV_BYPASS       8'h19
`define PEQ_EV_L2_ADDR      8'h21
`define PEQ_EV_L2_RDATA     8'h23
`define PEQ_UM_NONE         8'h00
`define PEQ_UM_FLOAT        8'h00
`define PEQ_UM_VECTOR       8'h01
`define PEQ_UM_LOAD         8'h02
`define PEQ_UM_CORE_LSB     6
`define PEQ_UM_CORE_BOTH    2'h3
`define PEQ_UM_CORE_THIS    2'h1
`endif
